// file: design/ics_core.sv
// How it works
// - working registers occupy data-space addresses 0 to 31.
// - top six registers form three 16-bit pointers with displacement, post-inc, pre-dec.
// - stack grows downward; pointer always addresses the stack top.
// - push lowers pointer by one; return address save lowers it by two.
// - pop raises pointer by one; return address restore raises it by two.
// - pointer is two 8-bit i/o registers, reset to top of RAM.
// - one undivided clock; fetch overlaps execution.
// - two-register ALU operation with write-back completes in one cycle.
// - each source has its own vector; lower vector means higher priority.
// - interrupt taken only with both its enable and global enable set.
// - boot lock bits can suppress interrupts depending on program region.
// - vector-select bit moves the vector table to the boot section.
// - boot-reset fuse moves the reset vector to the boot section.
// - taking an interrupt clears global enable; interrupt return sets it.
// - flag cleared when vectored and when software writes one to it.
// - flags latch while disabled and are served later by priority.
// - condition sources request only while their condition holds.
// - after interrupt return a pending interrupt can be taken at the very next boundary.
// - status register neither saved nor restored by hardware.
// - clear-global-enable blocks interrupts at once, same cycle included.
// - instruction after set-global-enable runs before pending interrupts.
// - response is four cycles pushing the pc; wake adds four.
// - interrupt return takes four cycles, sp plus two, enable set.
`timescale 1ns/1ps
module ics_core (
    input wire logic clk, // cpu clock
    input wire logic rst, // async reset, high
    input wire logic ioWr, // i/o write strobe
    input wire logic ioRd, // i/o read strobe
    input wire logic [5:0] ioAddr, // i/o offset
    input wire logic [7:0] ioWrData, // i/o write data
    input wire logic dsWr, // data-space write strobe
    input wire logic dsRd, // data-space read strobe
    input wire logic [15:0] dsAddr, // data-space address
    input wire logic [7:0] dsWrData, // data-space write data
    input wire logic ptrEn, // pointer access
    input wire logic [1:0] ptrSel, // 0 x, 1 y, 2 z
    input wire ics_pkg::ics_ptr_e ptrMode, // addressing mode
    input wire logic [5:0] ptrDisp, // displacement
    input wire logic aluEn, // alu operation
    input wire ics_pkg::ics_alu_e aluOp, // alu function
    input wire logic [4:0] aluRd, // destination register
    input wire logic [4:0] aluRr, // source register
    input wire ics_pkg::ics_seq_s seq, // sequencer status
    input wire logic [ics_pkg::NSRC-1:0] flagEvt, // flag-setting events
    input wire logic [ics_pkg::NSRC-1:0] condReq, // live conditions
    input wire logic [ics_pkg::NSRC-1:0] srcEn, // per-source enables
    input wire logic appLock, // app_boot_lock_bit programmed
    input wire logic bootLock, // boot_section_lock_bit programmed
    input wire logic bootRstFuse, // boot_reset_fuse programmed
    output logic [7:0] ioRdData, // i/o read data
    output logic [7:0] dsRdData, // register file read data
    output logic [15:0] ptrAddr, // effective pointer address
    output logic [15:0] sp, // stack pointer
    output logic gie, // global interrupt enable
    output logic irqTake, // vector fetch pulse
    output logic [ics_pkg::PCW-1:0] irqVec, // vector address
    output logic [2:0] irqSrc, // served source
    output logic retiDone, // interrupt return done pulse
    output logic [ics_pkg::PCW-1:0] resetVec, // reset vector
    output logic stkWr, // stack byte write
    output logic [15:0] stkAddr, // stack write address
    output logic [7:0] stkData // stack write data
);
    ics_pkg::ics_core_s st_r;
    ics_pkg::ics_core_s st_nxt;
    logic [ics_pkg::NSRC-1:0] reqVec;
    logic reqAny;
    logic [2:0] reqIdx;
    logic [ics_pkg::PCW-1:0] reqVecAddr;
    logic inhibit;
    logic takeNow;
    logic [ics_pkg::NSRC-1:0] swClr;
    logic [ics_pkg::NSRC-1:0] hwClr;
    logic [8:0] aluRes;
    logic [15:0] ptrBase;
    logic [15:0] ptrNew;
    logic [4:0] ptrLoIdx;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    function automatic logic [4:0] ptrLo(input logic [1:0] sel);
        unique case (sel)
            2'h0: ptrLo = ics_pkg::PTR_X_LO;
            2'h1: ptrLo = ics_pkg::PTR_Y_LO;
            default: ptrLo = ics_pkg::PTR_Z_LO;
        endcase
    endfunction

    // flag sources stay pending; condition sources are seen only while present
    assign reqVec = ((st_r.pend & ics_pkg::FLAG_TYPE_MASK)
        | (condReq & ~ics_pkg::FLAG_TYPE_MASK)) & srcEn;

    // boot lock: block from application code or from boot code respectively
    assign inhibit = (appLock && seq.pc < ics_pkg::BOOT_START)
        || (bootLock && seq.pc >= ics_pkg::BOOT_START);

    ics_prio ics_prio_i (
        .req(reqVec),
        .vector_select_bit(st_r.vector_select_bit),
        .any(reqAny),
        .idx(reqIdx),
        .vec(reqVecAddr)
    );

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.irqTake = 1'b0;
        st_nxt.retiDone = 1'b0;
        st_nxt.stkWr = 1'b0;
        st_nxt.resetVec = bootRstFuse ? ics_pkg::BOOT_START : '0;
        swClr = '0;
        hwClr = '0;
        takeNow = 1'b0;
        aluRes = '0;
        ptrBase = '0;
        ptrNew = '0;
        ptrLoIdx = ptrLo(ptrSel);

        st_nxt.ioRd = 8'h00;
        if (ioRd)
        begin
            unique case (ioAddr)
                ics_pkg::IO_SP_LOW: st_nxt.ioRd = st_r.sp[7:0];
                ics_pkg::IO_SP_HIGH: st_nxt.ioRd = st_r.sp[15:8];
                ics_pkg::IO_STATUS: st_nxt.ioRd = {st_r.gie, st_r.flg};
                ics_pkg::IO_MCU_CTRL: st_nxt.ioRd = 8'(st_r.vector_select_bit) << ics_pkg::VECTOR_SELECT_BIT_BIT;
                ics_pkg::IO_FLAG: st_nxt.ioRd = st_r.pend;
                default: st_nxt.ioRd = 8'h00;
            endcase
        end

        // register file answers only the bottom of data space
        st_nxt.dsRd = 8'h00;
        if (dsRd && dsAddr < ics_pkg::RF_SIZE)
        begin
            st_nxt.dsRd = st_r.rf[dsAddr[4:0]];
        end
        if (dsWr && dsAddr < ics_pkg::RF_SIZE)
        begin
            st_nxt.rf[dsAddr[4:0]] = dsWrData;
        end

        // operands read and result written back in the same cycle
        if (aluEn)
        begin
            unique case (aluOp)
                ics_pkg::ALU_ADD: aluRes = {1'b0, st_r.rf[aluRd]} + {1'b0, st_r.rf[aluRr]};
                ics_pkg::ALU_SUB: aluRes = {1'b0, st_r.rf[aluRd]} - {1'b0, st_r.rf[aluRr]};
                ics_pkg::ALU_AND: aluRes = {1'b0, st_r.rf[aluRd] & st_r.rf[aluRr]};
                ics_pkg::ALU_OR: aluRes = {1'b0, st_r.rf[aluRd] | st_r.rf[aluRr]};
                default: aluRes = {1'b0, st_r.rf[aluRr]};
            endcase
            st_nxt.rf[aluRd] = aluRes[7:0];
            if (aluOp != ics_pkg::ALU_MOV)
            begin
                st_nxt.flg[ics_pkg::FLG_C] = aluRes[8];
                st_nxt.flg[ics_pkg::FLG_Z] = (aluRes[7:0] == 8'h00);
                st_nxt.flg[ics_pkg::FLG_N] = aluRes[7];
            end
        end

        // pointer update wins over a same-cycle write to the pointer bytes
        if (ptrEn)
        begin
            ptrBase = {st_r.rf[ptrLoIdx + 5'h01], st_r.rf[ptrLoIdx]};
            unique case (ptrMode)
                ics_pkg::PTR_PLAIN: st_nxt.ptrAddr = ptrBase;
                ics_pkg::PTR_DISP: st_nxt.ptrAddr = ptrBase + {10'h000, ptrDisp};
                ics_pkg::PTR_POSTINC:
                begin
                    st_nxt.ptrAddr = ptrBase;
                    ptrNew = ptrBase + 16'h0001;
                    {st_nxt.rf[ptrLoIdx + 5'h01], st_nxt.rf[ptrLoIdx]} = ptrNew;
                end
                ics_pkg::PTR_PREDEC:
                begin
                    ptrNew = ptrBase - 16'h0001;
                    st_nxt.ptrAddr = ptrNew;
                    {st_nxt.rf[ptrLoIdx + 5'h01], st_nxt.rf[ptrLoIdx]} = ptrNew;
                end
            endcase
        end

        if (ioWr)
        begin
            unique case (ioAddr)
                ics_pkg::IO_SP_LOW: st_nxt.sp[7:0] = ioWrData;
                ics_pkg::IO_SP_HIGH: st_nxt.sp[15:8] = ioWrData;
                ics_pkg::IO_STATUS:
                begin
                    st_nxt.gie = ioWrData[ics_pkg::GIE_BIT];
                    st_nxt.flg = ioWrData[6:0];
                end
                ics_pkg::IO_MCU_CTRL: st_nxt.vector_select_bit = ioWrData[ics_pkg::VECTOR_SELECT_BIT_BIT];
                ics_pkg::IO_FLAG: swClr = ioWrData;
                default:
                begin
                end
            endcase
        end

        if (seq.sei)
        begin
            st_nxt.gie = 1'b1;
        end
        if (seq.clear_global_enable_instruction)
        begin
            st_nxt.gie = 1'b0;
        end

        unique case (st_r.st)
            ics_pkg::ST_RUN:
            begin
                unique case (seq.stkOp)
                    ics_pkg::STK_PUSH1: st_nxt.sp = st_r.sp - 16'h0001;
                    ics_pkg::STK_PUSH2: st_nxt.sp = st_r.sp - 16'h0002;
                    ics_pkg::STK_POP1: st_nxt.sp = st_r.sp + 16'h0001;
                    ics_pkg::STK_POP2: st_nxt.sp = st_r.sp + 16'h0002;
                    default:
                    begin
                    end
                endcase
                if (seq.interrupt_return_instruction)
                begin
                    st_nxt.st = ics_pkg::ST_INTERRUPT_RETURN_INSTRUCTION;
                    st_nxt.cnt = ics_pkg::INTERRUPT_RETURN_INSTRUCTION_CYC - 4'h1;
                end
                // gie_r is still low in the sei cycle, so the next instruction runs first
                else if (seq.boundary && st_r.gie && !seq.clear_global_enable_instruction && !seq.sei
                    && reqAny && !inhibit)
                begin
                    takeNow = 1'b1;
                    st_nxt.st = ics_pkg::ST_ENTRY;
                    st_nxt.cnt = seq.sleeping
                        ? ics_pkg::ENTRY_CYC + ics_pkg::WAKE_CYC - 4'h1
                        : ics_pkg::ENTRY_CYC - 4'h1;
                    st_nxt.gie = 1'b0;
                    st_nxt.srcIdx = reqIdx;
                    st_nxt.vec = reqVecAddr;
                    st_nxt.retPc = 16'(seq.pc);
                    hwClr[reqIdx] = ics_pkg::FLAG_TYPE_MASK[reqIdx];
                end
            end
            ics_pkg::ST_ENTRY:
            begin
                // status register deliberately left alone here
                st_nxt.cnt = st_r.cnt - 4'h1;
                if (st_r.cnt <= 4'h2)
                begin
                    st_nxt.stkWr = 1'b1;
                    st_nxt.stkAddr = st_r.sp;
                    st_nxt.stkData = (st_r.cnt == 4'h2) ? st_r.retPc[7:0] : st_r.retPc[15:8];
                    st_nxt.sp = st_r.sp - 16'h0001;
                end
                if (st_r.cnt == 4'h1)
                begin
                    st_nxt.st = ics_pkg::ST_RUN;
                    st_nxt.irqTake = 1'b1;
                end
            end
            ics_pkg::ST_INTERRUPT_RETURN_INSTRUCTION:
            begin
                st_nxt.cnt = st_r.cnt - 4'h1;
                if (st_r.cnt == 4'h1)
                begin
                    // back in run, a pending request is taken at the next boundary, which can be the next cycle
                    st_nxt.st = ics_pkg::ST_RUN;
                    st_nxt.sp = st_r.sp + 16'h0002;
                    st_nxt.gie = 1'b1;
                    st_nxt.retiDone = 1'b1;
                end
            end
            default:
            begin
                st_nxt.st = ics_pkg::ST_RUN;
            end
        endcase

        // a new event beats any clear in the same cycle
        st_nxt.pend = (st_r.pend & ~(swClr | hwClr)) | flagEvt;
    end

    // single undivided clock; the sequencer overlaps fetch with execution
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= '0;
            st_r.sp <= ics_pkg::TOP_OF_RAM_ADDRESS;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign ioRdData = st_r.ioRd;
    assign dsRdData = st_r.dsRd;
    assign ptrAddr = st_r.ptrAddr;
    assign sp = st_r.sp;
    assign gie = st_r.gie;
    assign irqTake = st_r.irqTake;
    assign irqVec = st_r.vec;
    assign irqSrc = st_r.srcIdx;
    assign retiDone = st_r.retiDone;
    assign resetVec = st_r.resetVec;
    assign stkWr = st_r.stkWr;
    assign stkAddr = st_r.stkAddr;
    assign stkData = st_r.stkData;

    spPush_one_a: assert property (
        seq.stkOp == ics_pkg::STK_PUSH1 && st_r.st == ics_pkg::ST_RUN
        |=> st_r.sp == $past(st_r.sp) - 16'h0001)
        else $error("single push did not lower sp by one");
    spPush_two_a: assert property (
        seq.stkOp == ics_pkg::STK_PUSH2 && st_r.st == ics_pkg::ST_RUN
        |=> st_r.sp == $past(st_r.sp) - 16'h0002)
        else $error("call push did not lower sp by two");
    spPop_two_a: assert property (
        seq.stkOp == ics_pkg::STK_POP2 && st_r.st == ics_pkg::ST_RUN
        |=> st_r.sp == $past(st_r.sp) + 16'h0002)
        else $error("return pop did not raise sp by two");
    take_needs_gie_a: assert property (
        takeNow |-> st_r.gie && srcEn[reqIdx])
        else $error("interrupt taken while disabled");
    gie_cleared_a: assert property (
        takeNow |=> !st_r.gie)
        else $error("global enable not cleared on entry");
    entry_time_a: assert property (
        takeNow && !seq.sleeping |=> !st_r.irqTake [*3] ##1 st_r.irqTake)
        else $error("entry did not last four cycles");
    wake_time_a: assert property (
        takeNow && seq.sleeping |-> ##8 st_r.irqTake)
        else $error("wake entry did not last eight cycles");
    cli_blocks_a: assert property (
        seq.clear_global_enable_instruction && st_r.st == ics_pkg::ST_RUN |=> st_r.st != ics_pkg::ST_ENTRY)
        else $error("interrupt taken in clear-enable cycle");
    interrupt_return_instruction_time_a: assert property (
        seq.interrupt_return_instruction && st_r.st == ics_pkg::ST_RUN
        |-> ##4 (st_r.retiDone && st_r.gie && st_r.sp == $past(st_r.sp, 4) + 16'h0002))
        else $error("interrupt return not four cycles with sp plus two");
    flag_hw_clear_a: assert property (
        takeNow && ics_pkg::FLAG_TYPE_MASK[reqIdx] && !flagEvt[reqIdx]
        |=> !st_r.pend[$past(reqIdx)])
        else $error("served flag not cleared");

    wake_entry_c: cover property (takeNow && seq.sleeping);
    interrupt_return_instruction_run_c: cover property (st_r.retiDone);
    cli_race_c: cover property (seq.clear_global_enable_instruction && seq.boundary && st_r.gie && reqAny);
    nested_c: cover property (st_r.st == ics_pkg::ST_ENTRY && ioWr && ioAddr == ics_pkg::IO_STATUS);
endmodule // ics_core

// file: design/ics_pkg.sv
package ics_pkg;

    localparam int NSRC = 8;
    localparam int PCW = 13;

    // data space layout
    localparam logic [15:0] TOP_OF_RAM_ADDRESS = 16'h04ff;
    localparam logic [15:0] RF_SIZE = 16'h0020;
    localparam logic [4:0] PTR_X_LO = 5'h1a;
    localparam logic [4:0] PTR_Y_LO = 5'h1c;
    localparam logic [4:0] PTR_Z_LO = 5'h1e;

    // program space: vectors are two words apart, reset takes slot zero
    localparam logic [PCW-1:0] BOOT_START = 13'h1c00;
    localparam logic [PCW-1:0] VEC_STEP = 13'h0002;

    // sources with a sticky flag; the rest request only while their condition holds
    localparam logic [NSRC-1:0] FLAG_TYPE_MASK = 8'h3f;

    // i/o space offsets
    localparam logic [5:0] IO_FLAG = 6'h20;
    localparam logic [5:0] IO_MCU_CTRL = 6'h35;
    localparam logic [5:0] IO_SP_LOW = 6'h3d;
    localparam logic [5:0] IO_SP_HIGH = 6'h3e;
    localparam logic [5:0] IO_STATUS = 6'h3f;

    // field positions
    localparam int GIE_BIT = 7;
    localparam int VECTOR_SELECT_BIT_BIT = 1;
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;

    // cycle counts
    localparam logic [3:0] ENTRY_CYC = 4'h4;
    localparam logic [3:0] WAKE_CYC = 4'h4;
    localparam logic [3:0] INTERRUPT_RETURN_INSTRUCTION_CYC = 4'h4;

    typedef enum logic [1:0] {ST_RUN, ST_ENTRY, ST_INTERRUPT_RETURN_INSTRUCTION} ics_state_e;
    typedef enum logic [2:0] {STK_NONE, STK_PUSH1, STK_POP1, STK_PUSH2, STK_POP2} ics_stk_e;
    typedef enum logic [1:0] {PTR_PLAIN, PTR_DISP, PTR_POSTINC, PTR_PREDEC} ics_ptr_e;
    typedef enum logic [2:0] {ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_MOV} ics_alu_e;

    typedef struct packed {
        logic boundary;
        logic sei;
        logic clear_global_enable_instruction;
        logic interrupt_return_instruction;
        logic sleeping;
        ics_stk_e stkOp;
        logic [PCW-1:0] pc;
    } ics_seq_s;

    typedef struct packed {
        ics_state_e st;
        logic [3:0] cnt;
        logic gie;
        logic [6:0] flg;
        logic vector_select_bit;
        logic [15:0] sp;
        logic [NSRC-1:0] pend;
        logic [2:0] srcIdx;
        logic [15:0] retPc;
        logic [PCW-1:0] vec;
        logic irqTake;
        logic retiDone;
        logic [PCW-1:0] resetVec;
        logic [7:0] ioRd;
        logic [7:0] dsRd;
        logic [15:0] ptrAddr;
        logic stkWr;
        logic [15:0] stkAddr;
        logic [7:0] stkData;
        logic [31:0][7:0] rf;
    } ics_core_s;

endpackage

// file: design/ics_prio.sv
`timescale 1ns/1ps
module ics_prio (
    input wire logic [ics_pkg::NSRC-1:0] req, // enabled pending requests
    input wire logic vector_select_bit, // vector table sits in boot section
    output logic any, // at least one request
    output logic [2:0] idx, // winning source
    output logic [ics_pkg::PCW-1:0] vec // its vector address
);
    logic [ics_pkg::PCW-1:0] base;

    // lowest index is lowest vector, hence highest priority
    always_comb
    begin
        any = 1'b0;
        idx = 3'h0;
        for (int i = ics_pkg::NSRC - 1; i >= 0; i--)
        begin
            if (req[i])
            begin
                any = 1'b1;
                idx = 3'(i);
            end
        end
        base = vector_select_bit ? ics_pkg::BOOT_START : '0;
        vec = base + (ics_pkg::PCW'(idx) + 13'h0001) * ics_pkg::VEC_STEP;
    end
endmodule // ics_prio

// file: dv/cpu_interrupt_and_stack_control_tb_top.sv
`timescale 1ns/1ps
module cpu_interrupt_and_stack_control_tb_top;
    logic clk, rst, ioWr, ioRd, dsWr, dsRd, ptrEn, aluEn, slow, seen, sleeping;
    logic appLock, bootLock, bootRstFuse, gie, irqTake, retiDone, stkWr;
    logic [5:0] ioAddr, ptrDisp;
    logic [7:0] ioWrData, dsWrData, ioRdData, dsRdData, stkData, flagEvt, condReq, srcEn;
    logic [15:0] dsAddr, ptrAddr, sp, stkAddr;
    logic [47:0] stkLog;
    logic [1:0] ptrSel, cmd;
    logic [4:0] aluRd, aluRr;
    logic [12:0] irqVec, resetVec;
    logic [2:0] irqSrc;
    ics_pkg::ics_ptr_e ptrMode;
    ics_pkg::ics_alu_e aluOp;
    ics_pkg::ics_stk_e stk;
    ics_pkg::ics_seq_s seq;
    int err_total = 0;
    int n_checks = 0;
    int i;
    // rows: {pad, i/o offset, write value, expected read}
    logic [23:0] ioRows [5] = '{{2'h0, ics_pkg::IO_SP_LOW, 16'h8080},
        {2'h0, ics_pkg::IO_SP_HIGH, 16'h0303}, {2'h0, 6'h01, 16'h5500},
        {2'h0, ics_pkg::IO_SP_HIGH, 16'h0404}, {2'h0, ics_pkg::IO_SP_LOW, 16'hffff}};
    ics_pkg::ics_stk_e ops [4] = '{ics_pkg::STK_PUSH1, ics_pkg::STK_PUSH2,
        ics_pkg::STK_POP1, ics_pkg::STK_POP2};
    logic [15:0] spExp [4] = '{16'h04fe, 16'h04fc, 16'h04fd, 16'h04ff};

    ics_seq_model ics_seq_model_i (.clk, .rst, .slow, .sleeping, .cmd, .stk, .seq);
    ics_core ics_core_i (.clk, .rst, .ioWr, .ioRd, .ioAddr, .ioWrData, .dsWr, .dsRd,
        .dsAddr, .dsWrData, .ptrEn, .ptrSel, .ptrMode, .ptrDisp, .aluEn, .aluOp, .aluRd,
        .aluRr, .seq, .flagEvt, .condReq, .srcEn, .appLock, .bootLock, .bootRstFuse,
        .ioRdData, .dsRdData, .ptrAddr, .sp, .gie, .irqTake, .irqVec, .irqSrc, .retiDone,
        .resetVec, .stkWr, .stkAddr, .stkData);

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // stack ram writes in order, the oldest ends up in the upper half
    always @(posedge clk)
        if (stkWr === 1'b1)
            stkLog <= {stkLog[23:0], stkAddr, stkData};

    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // outputs are sampled at the edge, so they show the previous cycle's settled value
    task io(input logic wr, input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        ioWr <= wr;
        ioRd <= ~wr;
        ioAddr <= a;
        ioWrData <= d;
        @(posedge clk);
        ioWr <= 1'b0;
        ioRd <= 1'b0;
        @(posedge clk);
    endtask

    task ds(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        dsWr <= wr;
        dsRd <= ~wr;
        dsAddr <= a;
        dsWrData <= d;
        @(posedge clk);
        dsWr <= 1'b0;
        dsRd <= 1'b0;
        @(posedge clk);
    endtask

    task ptr(input ics_pkg::ics_ptr_e m);
        @(posedge clk);
        ptrEn <= 1'b1;
        ptrMode <= m;
        @(posedge clk);
        ptrEn <= 1'b0;
        @(posedge clk);
    endtask

    task pulse(input logic [1:0] c);
        @(posedge clk);
        cmd <= c;
        @(posedge clk);
        cmd <= 2'h0;
    endtask

    task waitTake(input logic [12:0] v, input logic [2:0] s);
        for (i = 0; i < 40 && irqTake !== 1'b1; i++)
            @(posedge clk);
        if (i == 40)
        begin
            err_total++;
            end_of_test();
        end
        chk(irqVec, v);
        chk(irqSrc, s);
        chk(gie, 0);
    endtask

    task waitReti;
        pulse(2'h3);
        for (i = 0; i < 40 && retiDone !== 1'b1; i++)
            @(posedge clk);
        if (i == 40)
        begin
            err_total++;
            end_of_test();
        end
        @(posedge clk);
        chk(gie, 1);
        chk(sp, 16'h04ff);
    endtask

    task noTake;
        seen = 1'b0;
        repeat (10)
        begin
            @(posedge clk);
            if (irqTake === 1'b1)
                seen = 1'b1;
        end
    endtask

    initial
    begin
        {ioWr, ioRd, dsWr, dsRd, ptrEn, aluEn, slow, appLock, bootLock, bootRstFuse, sleeping} = '0;
        {ioAddr, ptrDisp, ioWrData, dsWrData, flagEvt, condReq, dsAddr} = '0;
        {ptrSel, cmd, aluRd, aluRr} = '0;
        srcEn = 8'hff;
        ptrMode = ics_pkg::PTR_PLAIN;
        aluOp = ics_pkg::ALU_ADD;
        stk = ics_pkg::STK_NONE;
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(sp, 16'h04ff);
        chk(gie, 0);
        @(posedge clk);
        chk(resetVec, 13'h0000);
        $display("test reset done");
        for (int r = 0; r < 5; r++)
        begin
            io(1'b1, ioRows[r][21:16], ioRows[r][15:8]);
            io(1'b0, ioRows[r][21:16], 8'h00);
            chk(ioRdData, ioRows[r][7:0]);
        end
        chk(sp, 16'h04ff);
        for (int r = 0; r < 4; r++)
        begin
            @(posedge clk);
            stk <= ops[r];
            @(posedge clk);
            stk <= ics_pkg::STK_NONE;
            @(posedge clk);
            chk(sp, spExp[r]);
        end
        $display("test table done");
        ds(1'b1, 16'h0001, 8'h05);
        ds(1'b1, 16'h0002, 8'h03);
        @(posedge clk);
        {aluEn, aluRd, aluRr} <= {1'b1, 5'h01, 5'h02};
        @(posedge clk);
        aluEn <= 1'b0;
        ds(1'b0, 16'h0001, 8'h00);
        chk(dsRdData, 8'h08);
        ds(1'b0, 16'h0020, 8'h00);
        chk(dsRdData, 8'h00);
        ds(1'b1, 16'h001a, 8'hff);
        ds(1'b1, 16'h001b, 8'h00);
        ptr(ics_pkg::PTR_POSTINC);
        chk(ptrAddr, 16'h00ff);
        ds(1'b0, 16'h001b, 8'h00);
        chk(dsRdData, 8'h01);
        ptr(ics_pkg::PTR_PREDEC);
        chk(ptrAddr, 16'h00ff);
        ptrSel <= 2'h1;
        ptrDisp <= 6'h05;
        ptr(ics_pkg::PTR_DISP);
        chk(ptrAddr, 16'h0005);
        $display("test regfile done");
        @(posedge clk);
        flagEvt <= 8'h14;
        @(posedge clk);
        flagEvt <= 8'h00;
        io(1'b0, ics_pkg::IO_FLAG, 8'h00);
        chk(ioRdData, 8'h14);
        slow <= 1'b1;
        pulse(2'h1);
        waitTake(13'h0006, 3'h2);
        chk(sp, 16'h04fd);
        io(1'b0, ics_pkg::IO_FLAG, 8'h00);
        chk(ioRdData, 8'h10);
        chk(stkLog[47:32], 16'h04ff);
        chk(16'(stkLog[31:24]), 16'h0023);
        chk(stkLog[23:8], 16'h04fe);
        chk(16'(stkLog[7:0]), 16'h0001);
        waitReti();
        waitTake(13'h000a, 3'h4);
        waitReti();
        $display("test irq done");
        @(posedge clk);
        srcEn <= 8'hfe;
        flagEvt <= 8'h01;
        // boundary every cycle, so the clear-enable cycle is also a boundary
        slow <= 1'b0;
        @(posedge clk);
        flagEvt <= 8'h00;
        @(posedge clk);
        srcEn <= 8'hff;
        cmd <= 2'h2;
        @(posedge clk);
        cmd <= 2'h0;
        noTake();
        chk(seen, 0);
        io(1'b1, ics_pkg::IO_MCU_CTRL, 8'h02);
        pulse(2'h1);
        waitTake(13'h1c02, 3'h0);
        waitReti();
        pulse(2'h2);
        @(posedge clk);
        condReq <= 8'h40;
        @(posedge clk);
        condReq <= 8'h00;
        pulse(2'h1);
        noTake();
        chk(seen, 0);
        @(posedge clk);
        condReq <= 8'h40;
        waitTake(13'h1c0e, 3'h6);
        condReq <= 8'h00;
        bootRstFuse <= 1'b1;
        repeat (3) @(posedge clk);
        chk(resetVec, 13'h1c00);
        waitReti();
        pulse(2'h2);
        @(posedge clk);
        flagEvt <= 8'h18;
        @(posedge clk);
        flagEvt <= 8'h00;
        io(1'b1, ics_pkg::IO_FLAG, 8'h08);
        io(1'b0, ics_pkg::IO_FLAG, 8'h00);
        chk(ioRdData, 8'h10);
        appLock <= 1'b1;
        pulse(2'h1);
        noTake();
        chk(seen, 0);
        // lock released while asleep: one edge to take, then four plus four
        appLock <= 1'b0;
        sleeping <= 1'b1;
        waitTake(13'h1c0a, 3'h4);
        chk(16'(i), 16'h0009);
        sleeping <= 1'b0;
        waitReti();
        $display("test awkward done");
        end_of_test();
    end
endmodule // cpu_interrupt_and_stack_control_tb_top

// file: dv/ics_seq_model.sv
`timescale 1ns/1ps
module ics_seq_model (
    input wire logic clk, // cpu clock
    input wire logic rst, // async reset, high
    input wire logic slow, // boundary only every other cycle
    input wire logic sleeping, // core asleep, entry gets the wake delay
    input wire logic [1:0] cmd, // 1 sei, 2 cli, 3 interrupt_return_instruction
    input wire ics_pkg::ics_stk_e stk, // stack op this cycle
    output ics_pkg::ics_seq_s seq // sequencer status
);
    logic bnd_r;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            bnd_r <= 1'b0;
        else
            bnd_r <= slow ? ~bnd_r : 1'b1;
    end
    // pc kept in the application region; slow mode mimics multi-cycle instructions
    always_comb
    begin
        seq = '0;
        seq.boundary = bnd_r;
        seq.sei = cmd == 2'h1;
        seq.clear_global_enable_instruction = cmd == 2'h2;
        seq.interrupt_return_instruction = cmd == 2'h3;
        seq.stkOp = stk;
        seq.sleeping = sleeping;
        seq.pc = 13'h0123;
    end
endmodule // ics_seq_model
